/* File: hdl/ser_pkg.sv */
// Purpose: Shared constants and types of the status enable and condition bank
// Assumes: 16-bit register sets, one clock
// Notes:   Bit positions give the weight of each status event

// ****************************************************************************
// Package
// ****************************************************************************
package ser_pkg;

  localparam int SER_W     = 16;
  localparam int SER_NSETS = 3;

  // Register set index
  localparam logic [1:0] SER_SET_MEAS = 2'h0;
  localparam logic [1:0] SER_SET_QUES = 2'h1;
  localparam logic [1:0] SER_SET_OPER = 2'h2;

  // Measurement bit positions
  localparam int SER_READING_OVERRANGE   = 0;
  localparam int SER_LOWER_LIMIT_ONE     = 1;
  localparam int SER_UPPER_LIMIT_ONE     = 2;
  localparam int SER_LOWER_LIMIT_TWO     = 3;
  localparam int SER_UPPER_LIMIT_TWO     = 4;
  localparam int SER_READING_READY       = 5;
  localparam int SER_BUFFER_HAS_READINGS = 7;
  localparam int SER_BUFFER_HALF_FLAG    = 8;
  localparam int SER_BUFFER_FULL_FLAG    = 9;

  // Questionable bit positions
  localparam int SER_TEMP_SUMMARY = 4;
  localparam int SER_CAL_SUMMARY  = 8;
  localparam int SER_CMD_WARNING  = 14;

  // Operation bit positions
  localparam int SER_MEASURING  = 4;
  localparam int SER_TRIGGERING = 5;
  localparam int SER_IDLE       = 10;

  localparam logic [SER_W-1:0] SER_ONE      = 16'h0001;
  localparam logic [SER_W-1:0] SER_MASK_RST = 16'h0000;
  localparam logic [SER_W-1:0] SER_ALL      = 16'hFFFF;

  localparam logic [SER_W-1:0] SER_MEAS_IMPL =
    (SER_ONE << SER_READING_OVERRANGE) | (SER_ONE << SER_LOWER_LIMIT_ONE) |
    (SER_ONE << SER_UPPER_LIMIT_ONE) | (SER_ONE << SER_LOWER_LIMIT_TWO) |
    (SER_ONE << SER_UPPER_LIMIT_TWO) | (SER_ONE << SER_READING_READY) |
    (SER_ONE << SER_BUFFER_HAS_READINGS) | (SER_ONE << SER_BUFFER_HALF_FLAG) |
    (SER_ONE << SER_BUFFER_FULL_FLAG);
  localparam logic [SER_W-1:0] SER_QUES_IMPL =
    (SER_ONE << SER_TEMP_SUMMARY) | (SER_ONE << SER_CAL_SUMMARY) |
    (SER_ONE << SER_CMD_WARNING);
  localparam logic [SER_W-1:0] SER_OPER_IMPL =
    (SER_ONE << SER_MEASURING) | (SER_ONE << SER_TRIGGERING) |
    (SER_ONE << SER_IDLE);

  localparam logic [SER_W-1:0] SER_IMPL [SER_NSETS] =
    '{SER_MEAS_IMPL, SER_QUES_IMPL, SER_OPER_IMPL};

  typedef enum logic [2:0] {
    SER_OP_NONE,
    SER_OP_WR_MASK,
    SER_OP_RD_MASK,
    SER_OP_RD_COND,
    SER_OP_RD_EVENT,
    SER_OP_PRESET
  } ser_op_t;

endpackage

/* File: hdl/ser_reg_set.sv */
// Purpose: One status register set: condition, event, enable mask, summary
// Assumes: Condition pins are asynchronous to mclk
// Notes:   Unimplemented bit positions never store and read as zero

`timescale 1ns/1ps

module ser_reg_set import ser_pkg::*; #(
  parameter int              WIDTH = SER_W,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  input  wire logic             mclk,        // System clock
  input  wire logic             rst_n,       // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] condPin,     // Live status inputs
  input  wire logic             maskWe,      // Mask write strobe
  input  wire logic [WIDTH-1:0] maskWrData,  // Mask write value
  input  wire logic             presetClr,   // Status preset strobe
  input  wire logic             eventRdClr,  // Event read strobe
  output logic      [WIDTH-1:0] condOut,     // Condition register
  output logic      [WIDTH-1:0] eventOut,    // Event register
  output logic      [WIDTH-1:0] maskOut,     // Enable mask register
  output logic                  summaryOut   // Summary bit of this set, sent to the bank's summary output
);

  // **************************************************************************
  // Elaboration check
  // **************************************************************************
  if (WIDTH < 1) begin : gBadWidth
    $error("ser_reg_set: WIDTH must be at least one");
  end

  // **************************************************************************
  // Registers
  // **************************************************************************
  logic [WIDTH-1:0] syncA_q;
  logic [WIDTH-1:0] cond_q;
  logic [WIDTH-1:0] condPrev_q;
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] event_d;
  logic [WIDTH-1:0] mask_q;
  logic [WIDTH-1:0] mask_d;
  logic             summary_q;
  wire  [WIDTH-1:0] rise;

  assign rise    = cond_q & ~condPrev_q;
  // New events win over the read clear
  assign event_d = (event_q & ~{WIDTH{eventRdClr}}) | rise;
  // Preset wins over a write in the same cycle
  assign mask_d  = presetClr ? '0 :
                   maskWe ? (maskWrData & IMPL) : mask_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncA_q    <= '0;
      cond_q     <= '0;
      condPrev_q <= '0;
      event_q    <= '0;
      mask_q     <= '0;
      summary_q  <= 1'b0;
    end else begin
      syncA_q    <= condPin & IMPL;
      cond_q     <= syncA_q;
      condPrev_q <= cond_q;
      event_q    <= event_d;
      mask_q     <= mask_d;
      summary_q  <= |(event_q & mask_q);
    end
  end

  assign condOut    = cond_q;
  assign eventOut   = event_q;
  assign maskOut    = mask_q;
  assign summaryOut = summary_q;

  // **************************************************************************
  // Assertions
  // **************************************************************************
  AST_EVT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    eventRdClr |=> (event_q & ~$past(rise)) == '0)
    else $error("event bits survived a read");

  AST_EVT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !eventRdClr |=> (event_q & $past(event_q)) == $past(event_q))
    else $error("event bit lost without a read");

endmodule

/* File: hdl/ser_status_regs.sv */
// Purpose: Enable masks and condition registers of the status structure
// Assumes: Host commands arrive decoded on mclk; status pins are asynchronous
// Notes:   Reads answer one cycle after the command is taken

`timescale 1ns/1ps

module ser_status_regs import ser_pkg::*; (
  input  wire logic             mclk,         // System clock, 40 MHz
  input  wire logic             rst_n,        // Synchronous reset, active low
  input  wire logic             cmdValid,     // Command strobe
  input  wire ser_op_t          cmdOp,        // Command operation
  input  wire logic [1:0]       cmdSet,       // Addressed register set
  input  wire logic [SER_W-1:0] cmdData,      // Mask write value
  input  wire logic [SER_W-1:0] measCondPin,  // Measurement status pins
  input  wire logic [SER_W-1:0] quesCondPin,  // Questionable status pins
  input  wire logic [SER_W-1:0] operCondPin,  // Operation status pins
  output logic                  rspValid,     // Read answer strobe
  output logic      [SER_W-1:0] rspData,      // Read answer value
  output logic                  measSummary,  // Measurement summary bit
  output logic                  quesSummary,  // Questionable summary bit
  output logic                  operSummary   // Operation summary bit
);

  // **************************************************************************
  // Elaboration checks
  // **************************************************************************
  if (SER_NSETS != 3) begin : gBadSets
    $error("ser_status_regs: exactly three register sets are served");
  end
  if (SER_W != 16) begin : gBadWidth
    $error("ser_status_regs: registers are sixteen bits wide");
  end
  if (SER_QUES_IMPL[SER_W-1]) begin : gBadQues
    $error("ser_status_regs: questionable bit 15 must stay unused");
  end
  if (SER_SET_OPER != 2'(SER_NSETS - 1)) begin : gBadIndex
    $error("ser_status_regs: set index does not fit the set count");
  end

  // **************************************************************************
  // Command decode
  // **************************************************************************
  wire logic [SER_W-1:0] condPin [SER_NSETS];
  wire logic [SER_W-1:0] condV   [SER_NSETS];
  wire logic [SER_W-1:0] eventV  [SER_NSETS];
  wire logic [SER_W-1:0] maskV   [SER_NSETS];
  wire logic             summV   [SER_NSETS];
  wire logic             sel     [SER_NSETS];
  wire logic             maskWe  [SER_NSETS];
  wire logic             evtClr  [SER_NSETS];
  wire logic             setOk;
  wire logic             preset;
  wire logic             isRead;
  wire logic             isWrMask;
  wire logic             isRdMask;
  wire logic             isRdCond;
  wire logic             isRdEvent;
  wire logic             rdHit;
  wire logic [SER_W-1:0] rdMask;
  wire logic [SER_W-1:0] rdCond;
  wire logic [SER_W-1:0] rdEvent;
  wire logic [SER_W-1:0] rdData;

  assign condPin[SER_SET_MEAS] = measCondPin;
  assign condPin[SER_SET_QUES] = quesCondPin;
  assign condPin[SER_SET_OPER] = operCondPin;

  assign isWrMask  = cmdOp == SER_OP_WR_MASK;
  assign isRdMask  = cmdOp == SER_OP_RD_MASK;
  assign isRdCond  = cmdOp == SER_OP_RD_COND;
  assign isRdEvent = cmdOp == SER_OP_RD_EVENT;
  assign setOk     = cmdSet <= SER_SET_OPER;
  assign preset    = cmdValid && (cmdOp == SER_OP_PRESET);
  assign isRead    = isRdMask || isRdCond || isRdEvent;
  assign rdHit     = cmdValid && isRead;

  // Unknown set reads as zero
  assign rdMask  = setOk ? maskV[cmdSet]  : SER_MASK_RST;
  assign rdCond  = setOk ? condV[cmdSet]  : SER_MASK_RST;
  assign rdEvent = setOk ? eventV[cmdSet] : SER_MASK_RST;
  assign rdData  = isRdMask ? rdMask :
                   isRdCond ? rdCond : rdEvent;

  // **************************************************************************
  // Register sets
  // **************************************************************************
  for (genvar g = 0; g < SER_NSETS; g++) begin : gSet
    assign sel[g]    = cmdValid && setOk && (cmdSet == 2'(g));
    assign maskWe[g] = sel[g] && isWrMask;
    assign evtClr[g] = sel[g] && isRdEvent;

    // One condition register per set
    ser_reg_set #(
      .WIDTH (SER_W),
      .IMPL  (SER_IMPL[g])
    ) uSet (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .condPin    (condPin[g]),
      .maskWe     (maskWe[g]),
      .maskWrData (cmdData),
      .presetClr  (preset),
      .eventRdClr (evtClr[g]),
      .condOut    (condV[g]),
      .eventOut   (eventV[g]),
      .maskOut    (maskV[g]),
      .summaryOut (summV[g])
    );
  end

  assign measSummary = summV[SER_SET_MEAS];
  assign quesSummary = summV[SER_SET_QUES];
  assign operSummary = summV[SER_SET_OPER];

  // **************************************************************************
  // Read answer
  // **************************************************************************
  logic             rspValid_q;
  logic [SER_W-1:0] rspData_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      rspData_q  <= SER_MASK_RST;
    end else begin
      rspValid_q <= rdHit;
      if (rdHit) begin
        rspData_q <= rdData;
      end
    end
  end

  assign rspValid = rspValid_q;
  assign rspData  = rspData_q;

  // **************************************************************************
  // Assertions
  // **************************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  for (genvar a = 0; a < SER_NSETS; a++) begin : gAst
    AST_SUM_BLOCK: assert property (
      (eventV[a] & maskV[a]) == SER_MASK_RST |=> !summV[a])
      else $error("masked event raised summary");

    AST_SUM_SET: assert property (
      (eventV[a] & maskV[a]) != SER_MASK_RST |=> summV[a])
      else $error("enabled event did not raise summary");

    AST_MASK_WR: assert property (
      maskWe[a] && !preset |=> maskV[a] == ($past(cmdData) & SER_IMPL[a]))
      else $error("mask write not stored");

    AST_COND_TRACK: assert property (
      ##3 condV[a] == ($past(condPin[a], 2) & SER_IMPL[a]))
      else $error("condition does not follow pins");

    AST_COND_READ: assert property (
      sel[a] && cmdOp == SER_OP_RD_COND |=>
        rspValid && rspData == $past(condV[a]))
      else $error("condition read wrong");

    AST_PRESET_CLR: assert property (
      preset |=> maskV[a] == SER_MASK_RST [*1] ##1 1'b1)
      else $error("preset left a mask bit set");

    AST_PRESET_KEEP: assert property (
      preset |=> (eventV[a] & $past(eventV[a])) == $past(eventV[a]))
      else $error("preset cleared an event bit");

    AST_EVT_READ: assert property (
      evtClr[a] |=> rspValid && rspData == $past(eventV[a]))
      else $error("event read returned wrong value");

    AST_MASK_READ: assert property (
      sel[a] && cmdOp == SER_OP_RD_MASK |=>
        rspData == $past(maskV[a]) && $stable(maskV[a]))
      else $error("mask read wrong or altered mask");

    AST_NO_WR_HOLD: assert property (
      !maskWe[a] && !preset |=> $stable(maskV[a]))
      else $error("mask changed without a write");

    AST_COND_CLEAN: assert property (
      ((condV[a] | eventV[a]) & ~SER_IMPL[a]) == SER_MASK_RST)
      else $error("unused condition or event bit set");

    AST_COND_RD_KEEP: assert property (
      sel[a] && isRdCond |=>
        $stable(maskV[a]) && ($past(eventV[a]) & ~eventV[a]) == SER_MASK_RST)
      else $error("condition read altered a register");
  end

  AST_MEAS_MAP: assert property (
    (maskV[SER_SET_MEAS] & ~SER_MEAS_IMPL) == SER_MASK_RST)
    else $error("unused measurement mask bit set");

  AST_QUES_MAP: assert property (
    (maskV[SER_SET_QUES] & ~SER_QUES_IMPL) == SER_MASK_RST &&
    !maskV[SER_SET_QUES][SER_W-1])
    else $error("unused questionable mask bit set");

  AST_OPER_MAP: assert property (
    (maskV[SER_SET_OPER] & ~SER_OPER_IMPL) == SER_MASK_RST)
    else $error("unused operation mask bit set");

  AST_ALL_BITS: assert property (
    maskWe[SER_SET_MEAS] && !preset && cmdData == SER_ALL |=>
      maskV[SER_SET_MEAS] == SER_MEAS_IMPL)
    else $error("all-ones write did not set every bit");

  AST_RSP_PULSE: assert property (
    rspValid |-> $past(rdHit))
    else $error("answer without a read");

  AST_NO_RSP: assert property (
    !rdHit |=> !rspValid)
    else $error("spurious answer");

  AST_RSP_HOLD: assert property (
    !rdHit |=> $stable(rspData))
    else $error("answer changed without a read");

  AST_BAD_SET_RD: assert property (
    rdHit && !setOk |=> rspValid && rspData == SER_MASK_RST)
    else $error("read of no set did not answer zero");

  AST_BAD_SET_WR: assert property (
    cmdValid && isWrMask && !setOk |=>
      $stable(maskV[SER_SET_MEAS]) && $stable(maskV[SER_SET_QUES]) &&
      $stable(maskV[SER_SET_OPER]))
    else $error("write to no set changed a mask");

  AST_PRESET_SUM: assert property (
    preset |=> ##1 !measSummary && !quesSummary && !operSummary)
    else $error("summary survived a preset");

  AST_MEAS_ROF: assert property (
    maskWe[SER_SET_MEAS] && cmdData[SER_READING_OVERRANGE] |=>
      maskV[SER_SET_MEAS][SER_READING_OVERRANGE])
    else $error("overrange enable not stored");

  AST_MEAS_RAV: assert property (
    maskWe[SER_SET_MEAS] && cmdData[SER_READING_READY] |=>
      maskV[SER_SET_MEAS][SER_READING_READY])
    else $error("reading ready enable not stored");

  AST_MEAS_FULL: assert property (
    maskWe[SER_SET_MEAS] && cmdData[SER_BUFFER_FULL_FLAG] |=>
      maskV[SER_SET_MEAS][SER_BUFFER_FULL_FLAG])
    else $error("buffer full enable not stored");

  AST_QUES_TEMP: assert property (
    maskWe[SER_SET_QUES] && cmdData[SER_TEMP_SUMMARY] |=>
      maskV[SER_SET_QUES][SER_TEMP_SUMMARY])
    else $error("temperature enable not stored");

  AST_QUES_CAL: assert property (
    maskWe[SER_SET_QUES] && cmdData[SER_CAL_SUMMARY] |=>
      maskV[SER_SET_QUES][SER_CAL_SUMMARY])
    else $error("calibration enable not stored");

  AST_QUES_WARN: assert property (
    maskWe[SER_SET_QUES] && cmdData[SER_CMD_WARNING] |=>
      maskV[SER_SET_QUES][SER_CMD_WARNING])
    else $error("command warning enable not stored");

  AST_OPER_MEAS: assert property (
    maskWe[SER_SET_OPER] && cmdData[SER_MEASURING] |=>
      maskV[SER_SET_OPER][SER_MEASURING])
    else $error("measuring enable not stored");

  AST_OPER_TRIG: assert property (
    maskWe[SER_SET_OPER] && cmdData[SER_TRIGGERING] |=>
      maskV[SER_SET_OPER][SER_TRIGGERING])
    else $error("triggering enable not stored");

  AST_OPER_IDLE: assert property (
    maskWe[SER_SET_OPER] && cmdData[SER_IDLE] |=>
      maskV[SER_SET_OPER][SER_IDLE])
    else $error("idle enable not stored");

  // **************************************************************************
  // Covers
  // **************************************************************************
  COV_WR_SUM: cover property (
    maskWe[SER_SET_MEAS] ##[1:20] measSummary);

  COV_PRESET: cover property (
    maskV[SER_SET_OPER] != SER_MASK_RST ##0 preset);

  COV_EVT_READ: cover property (
    evtClr[SER_SET_QUES] && eventV[SER_SET_QUES] != SER_MASK_RST);

  COV_COND_READ: cover property (
    sel[SER_SET_MEAS] && cmdOp == SER_OP_RD_COND &&
    condV[SER_SET_MEAS][SER_BUFFER_FULL_FLAG]);

  COV_BAD_SET: cover property (
    rdHit && !setOk);

endmodule

/* File: tb/ser_host_model.sv */
// Purpose: Host side that issues status commands to the register bank
// Assumes: Commands change on the falling edge of mclk
// Notes:   Idle data shows the inverse of the last value sent

`timescale 1ns/1ps

module ser_host_model import ser_pkg::*; (
  input  wire logic             mclk,      // System clock
  output logic                  cmdValid,  // Command strobe
  output ser_op_t               cmdOp,     // Command operation
  output logic      [1:0]       cmdSet,    // Addressed set
  output logic      [SER_W-1:0] cmdData    // Mask value
);
  initial begin
    cmdValid = 1'b0;
    cmdOp    = SER_OP_NONE;
    cmdSet   = 2'h3;
    cmdData  = 16'h0000;
  end

  // One command, held for exactly one taking edge
  task automatic issue(input ser_op_t op, input logic [1:0] st, input logic [SER_W-1:0] d);
    @(negedge mclk);
    cmdValid = 1'b1;
    cmdOp    = op;
    cmdSet   = st;
    cmdData  = d;
    @(negedge mclk);
    cmdValid = 1'b0;
    cmdOp    = SER_OP_NONE;
    cmdData  = ~d;
  endtask
endmodule

/* File: tb/ser_status_regs_test.sv */
// Purpose: Self-checking bench of the status enable and condition bank
// Assumes: Inputs change on the falling edge; seed fixed
// Notes:   Expected weights are written out, not taken from the package

`timescale 1ns/1ps

module ser_status_regs_test import ser_pkg::*;;
  logic             mclk;
  logic             rst_n;
  logic             cmdValid;
  ser_op_t          cmdOp;
  logic [1:0]       cmdSet;
  logic [SER_W-1:0] cmdData;
  logic [SER_W-1:0] pinV [3];
  logic [SER_W-1:0] evtExp [3];
  logic             rspValid;
  logic [SER_W-1:0] rspData;
  logic             measSummary;
  logic             quesSummary;
  logic             operSummary;
  int               errors;
  int               comparisons;
  logic [1:0]       s;
  logic [SER_W-1:0] d;

  ser_host_model i_host (.mclk(mclk), .cmdValid(cmdValid), .cmdOp(cmdOp),
                         .cmdSet(cmdSet), .cmdData(cmdData));

  ser_status_regs i_dut (.mclk(mclk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdSet(cmdSet), .cmdData(cmdData), .measCondPin(pinV[0]),
    .quesCondPin(pinV[1]), .operCondPin(pinV[2]), .rspValid(rspValid),
    .rspData(rspData), .measSummary(measSummary), .quesSummary(quesSummary),
    .operSummary(operSummary));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ****
  // Helpers
  // ****
  function automatic logic [15:0] impl(input logic [1:0] st);
    return (st == 2'h0) ? 16'h03BF : (st == 2'h1) ? 16'h4110 :
           (st == 2'h2) ? 16'h0430 : 16'h0000;
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic readChk(input ser_op_t op, input logic [1:0] st, input logic [15:0] exp);
    int n;
    i_host.issue(op, st, 16'h0000);
    for (n = 0; n < 4 && rspValid !== 1'b1; n++) @(negedge mclk);
    if (rspValid !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    checkWord(rspData, exp);
    @(negedge mclk);
    checkBit(rspValid, 1'b0);
  endtask

  task automatic wrMask(input logic [1:0] st, input logic [15:0] v);
    i_host.issue(SER_OP_WR_MASK, st, v);
  endtask

  // Keep the expected event latch in step with each pin change
  task automatic setPin(input logic [1:0] st, input logic [15:0] v);
    evtExp[st] = evtExp[st] | (v & ~pinV[st] & impl(st));
    pinV[st]   = v;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    rst_n = 1'b0;
    for (int k = 0; k < 3; k++) begin
      pinV[k]   = 16'h0000;
      evtExp[k] = 16'h0000;
    end
    void'($urandom(38));
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    for (s = 0; s < 3; s++) readChk(SER_OP_RD_MASK, s, 16'h0000);
    $display("test reset done");
    for (s = 0; s < 3; s++) begin
      wrMask(s, 16'hFFFF);
      readChk(SER_OP_RD_MASK, s, impl(s));
      wrMask(s, 16'h0000);
      readChk(SER_OP_RD_MASK, s, 16'h0000);
    end
    wrMask(SER_SET_MEAS, 16'h0220);
    readChk(SER_OP_RD_MASK, SER_SET_MEAS, 16'h0220);
    readChk(SER_OP_RD_COND, 2'h3, 16'h0000);
    wrMask(2'h3, 16'hFFFF);
    readChk(SER_OP_RD_MASK, SER_SET_MEAS, 16'h0220);
    readChk(SER_OP_RD_MASK, SER_SET_OPER, 16'h0000);
    $display("test weights done");
    for (int i = 0; i < 40; i++) begin
      s = 2'($urandom % 3);
      d = 16'($urandom);
      setPin(s, 16'($urandom));
      wrMask(s, d);
      repeat (3) @(negedge mclk);
      readChk(SER_OP_RD_COND, s, pinV[s] & impl(s));
      readChk(SER_OP_RD_MASK, s, d & impl(s));
      readChk(SER_OP_RD_MASK, s, d & impl(s));
    end
    $display("test random done");
    for (int k = 0; k < 3; k++) pinV[k] = 16'h0000;
    repeat (6) @(negedge mclk);
    for (s = 0; s < 3; s++) begin
      readChk(SER_OP_RD_EVENT, s, evtExp[s]);
      wrMask(s, 16'h0000);
    end
    for (s = 0; s < 3; s++) readChk(SER_OP_RD_EVENT, s, 16'h0000);
    wrMask(SER_SET_MEAS, 16'h0200);
    wrMask(SER_SET_OPER, 16'h0400);
    pinV[0] = 16'h0200;
    pinV[1] = 16'h4110;
    pinV[2] = 16'h0030;
    repeat (6) @(negedge mclk);
    checkBit(measSummary, 1'b1);
    checkBit(quesSummary, 1'b0);
    checkBit(operSummary, 1'b0);
    wrMask(SER_SET_MEAS, 16'h0000);
    repeat (2) @(negedge mclk);
    checkBit(measSummary, 1'b0);
    pinV[2] = 16'h0430;
    repeat (6) @(negedge mclk);
    checkBit(operSummary, 1'b1);
    $display("test summary done");
    for (s = 0; s < 3; s++) wrMask(s, 16'hFFFF);
    i_host.issue(SER_OP_PRESET, 2'h3, 16'hFFFF);
    repeat (2) @(negedge mclk);
    checkBit(measSummary | quesSummary | operSummary, 1'b0);
    for (s = 0; s < 3; s++) begin
      readChk(SER_OP_RD_MASK, s, 16'h0000);
      readChk(SER_OP_RD_COND, s, pinV[s] & impl(s));
      readChk(SER_OP_RD_EVENT, s, pinV[s] & impl(s));
      readChk(SER_OP_RD_EVENT, s, 16'h0000);
    end
    $display("test preset done");
    tally_and_finish();
  end
endmodule
